// File: design/spsf_pkg.sv
package spsf_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] SPSF_OFF_STATUS = 8'h00;
  localparam logic [7:0] SPSF_OFF_DATA = 8'h04;
  localparam logic [7:0] SPSF_OFF_CTRL = 8'h08;
  localparam logic [7:0] SPSF_ADDR_MASK = 8'hFF;
  // ==========================================================
  // Status flag positions
  localparam int SPSF_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int SPSF_TC = 6;
  localparam int SPSF_RX_FULL_FLAG = 5;
  localparam int SPSF_IDLE = 4;
  localparam int SPSF_OVR = 3;
  localparam int SPSF_NF = 2;
  localparam int SPSF_FE = 1;
  localparam int SPSF_PF = 0;
  localparam logic [7:0] SPSF_STATUS_RST = 8'hC0;
  localparam logic [7:0] SPSF_RX_FLAGS = 8'h3F;
  localparam logic [7:0] SPSF_TX_FLAGS = 8'hC0;
  // ==========================================================
  // Control register bit positions
  localparam int SPSF_C_SBK = 0;
  localparam int SPSF_C_ILT = 1;
  localparam int SPSF_C_NINE = 2;
  localparam int SPSF_C_PE = 3;
  localparam int SPSF_C_PODD = 4;
  localparam int SPSF_C_TE = 5;
  localparam logic [5:0] SPSF_CTRL_RST = 6'h00;
  // ==========================================================
  // Frame geometry
  localparam logic [3:0] SPSF_CHAR_BITS_8 = 4'hA;
  localparam logic [3:0] SPSF_CHAR_BITS_9 = 4'hB;
  localparam logic [3:0] SPSF_DATA_BITS_8 = 4'h8;
  localparam logic [3:0] SPSF_DATA_BITS_9 = 4'h9;
  localparam int SPSF_START_SAMPLES = 7;
  localparam int SPSF_BIT_SAMPLES = 3;
endpackage : spsf_pkg

// File: design/spsf_status.sv
`timescale 1ns/1ns
// Behaviour
// - Buffer-empty set at reset and on shifter load
// - Done flag set when buffer empty, transmitter idle
// - Done clears: status read, then write/preamble/break
// - Receive-full set when character enters data register
// - Receive-full clears: status read, then data read
// - Idle set after one character time high
// - Idle-count select picks where counting begins
// - Idle clears: status read, then data read
// - Idle sets once, rearmed by new character
// - Overrun on unread data; new character dropped
// - Overrun clears: status read, then data read
// - Sample disagreement sets noise with receive-full
// - Noise clears: status read, then data read
// - Zero stop bit sets framing error
// - Framing clears: status read, then data read
// - Parity mismatch sets parity error when enabled
// - Parity clears: status read, then data read
// - Status register read-only, writes ignored
// - Character-length picks 8 or 9 data bits
// - Break request held while send-break set
module spsf_status (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_load,
  input wire logic tx_busy,
  output logic [8:0] tx_buf_data,
  output logic tx_buf_empty,
  output logic tx_preamble_req,
  output logic tx_break_req,
  output logic tx_enable,
  output logic cfg_nine_bit,
  output logic cfg_parity_en,
  output logic cfg_parity_odd,
  input wire logic rx_line,
  input wire logic bit_tick,
  input wire logic rx_start_strobe,
  input wire logic [6:0] rx_start_samples,
  input wire logic rx_bit_strobe,
  input wire logic [2:0] rx_bit_samples,
  input wire logic rx_stop_strobe,
  input wire logic [2:0] rx_stop_samples
);
  import spsf_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] flags;
    logic [7:0] armed;
    logic [5:0] ctrl;
    logic [8:0] tx_buf;
    logic pre_req;
    logic [8:0] rx_data;
    logic [8:0] rx_shift;
    logic rx_par;
    logic rx_noise;
    logic [3:0] rx_cnt;
    logic in_frame;
    logic [3:0] idle_cnt;
    logic idle_armed;
  } spsf_state_t;

  spsf_state_t st_reg;
  spsf_state_t st_next;
  logic rst_meta_reg;
  logic rst_sync_reg;

  // ==========================================================
  // Helpers
  function automatic logic spsf_maj3(input logic [2:0] s);
    spsf_maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : spsf_maj3

  function automatic logic spsf_noisy3(input logic [2:0] s);
    spsf_noisy3 = !((&s) || !(|s));
  endfunction : spsf_noisy3

  // Reset release through two stages; first stage read only by second
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Bus decode: one wait state so read data comes from a flop
  logic acc;
  logic wr_data;
  logic rd_data;
  logic rd_stat;
  logic wr_ctrl;
  logic mapped;
  logic te_rise;
  logic sbk_write;
  logic tx_clr;
  logic tc_clr;
  logic rx_clr;
  logic rx_ok;
  logic stop_bit;
  logic par_bad;
  logic [3:0] char_time;
  logic [3:0] data_bits;
  logic [7:0] set_v;
  logic [7:0] clr_v;

  always_comb begin
    acc = psel && penable && st_reg.pready;
    mapped = (paddr == SPSF_OFF_STATUS) || (paddr == SPSF_OFF_DATA) || (paddr == SPSF_OFF_CTRL);
    wr_data = acc && pwrite && (paddr == SPSF_OFF_DATA);
    rd_data = acc && !pwrite && (paddr == SPSF_OFF_DATA);
    rd_stat = acc && !pwrite && (paddr == SPSF_OFF_STATUS);
    wr_ctrl = acc && pwrite && (paddr == SPSF_OFF_CTRL);
    te_rise = wr_ctrl && pwdata[SPSF_C_TE] && !st_reg.ctrl[SPSF_C_TE];
    sbk_write = wr_ctrl && pwdata[SPSF_C_SBK];
    char_time = st_reg.ctrl[SPSF_C_NINE] ? SPSF_CHAR_BITS_9 : SPSF_CHAR_BITS_8;
    data_bits = st_reg.ctrl[SPSF_C_NINE] ? SPSF_DATA_BITS_9 : SPSF_DATA_BITS_8;
    stop_bit = spsf_maj3(rx_stop_samples);
    par_bad = st_reg.ctrl[SPSF_C_PE] && (st_reg.rx_par != st_reg.ctrl[SPSF_C_PODD]);
    // Clears act only on flags caught by the preceding status read
    tx_clr = wr_data;
    tc_clr = wr_data || te_rise || sbk_write;
    rx_clr = rd_data;
    rx_ok = rx_stop_strobe && (!st_reg.flags[SPSF_RX_FULL_FLAG] || (rx_clr && st_reg.armed[SPSF_RX_FULL_FLAG]));
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    set_v = 8'h00;
    clr_v = 8'h00;
    // Bus answer
    st_next.pready = psel && penable && !st_reg.pready;
    st_next.pslverr = psel && penable && !st_reg.pready && !mapped;
    st_next.prdata = 32'h0000_0000;
    if (psel && penable && !st_reg.pready && !pwrite) begin
      case (paddr)
        SPSF_OFF_STATUS: st_next.prdata = {24'h00_0000, st_reg.flags};
        SPSF_OFF_DATA: st_next.prdata = {23'h00_0000, st_reg.rx_data};
        SPSF_OFF_CTRL: st_next.prdata = {26'h000_0000, st_reg.ctrl};
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end
    // Control and transmit buffer; status writes fall through untouched
    if (wr_ctrl) begin
      st_next.ctrl = pwdata[5:0];
    end
    if (wr_data) begin
      st_next.tx_buf = pwdata[8:0];
    end
    if (te_rise) begin
      st_next.pre_req = 1'b1;
    end else if (tx_load) begin
      st_next.pre_req = 1'b0;
    end
    // Clear masks from latched flags
    if (tx_clr) begin
      clr_v[SPSF_TX_BUFFER_EMPTY_FLAG] = st_reg.armed[SPSF_TX_BUFFER_EMPTY_FLAG];
    end
    if (tc_clr) begin
      clr_v[SPSF_TC] = st_reg.armed[SPSF_TC];
    end
    if (rx_clr) begin
      clr_v = clr_v | (st_reg.armed & SPSF_RX_FLAGS);
    end
    // Hardware set events
    set_v[SPSF_TX_BUFFER_EMPTY_FLAG] = tx_load;
    set_v[SPSF_TC] = st_reg.flags[SPSF_TX_BUFFER_EMPTY_FLAG] && !tx_busy && !st_reg.pre_req
                     && !st_reg.ctrl[SPSF_C_SBK] && !tc_clr;
    // Receive shifter bookkeeping
    if (rx_start_strobe) begin
      st_next.in_frame = 1'b1;
      st_next.rx_cnt = 4'h0;
      st_next.rx_par = 1'b0;
      st_next.rx_shift = 9'h000;
      st_next.rx_noise = !((&rx_start_samples) || !(|rx_start_samples));
    end else if (rx_bit_strobe && st_reg.rx_cnt < data_bits) begin
      st_next.rx_shift = {spsf_maj3(rx_bit_samples), st_reg.rx_shift[8:1]};
      st_next.rx_par = st_reg.rx_par ^ spsf_maj3(rx_bit_samples);
      st_next.rx_noise = st_reg.rx_noise | spsf_noisy3(rx_bit_samples);
      st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
    end
    if (rx_stop_strobe) begin
      st_next.in_frame = 1'b0;
      if (rx_ok) begin
        // Accept: data and its error bits land together
        st_next.rx_data = st_reg.ctrl[SPSF_C_NINE] ? st_reg.rx_shift : {1'b0, st_reg.rx_shift[8:1]};
        set_v[SPSF_RX_FULL_FLAG] = 1'b1;
        set_v[SPSF_NF] = st_reg.rx_noise | spsf_noisy3(rx_stop_samples);
        set_v[SPSF_FE] = !stop_bit;
        set_v[SPSF_PF] = par_bad;
        st_next.idle_armed = 1'b1;
        clr_v[SPSF_NF] = 1'b1;
        clr_v[SPSF_FE] = 1'b1;
        clr_v[SPSF_PF] = 1'b1;
      end else begin
        set_v[SPSF_OVR] = 1'b1;
      end
    end
    // Idle detection counted in bit times of high line
    if (bit_tick) begin
      if (!rx_line || (st_reg.ctrl[SPSF_C_ILT] && st_reg.in_frame)) begin
        st_next.idle_cnt = 4'h0;
      end else if (st_reg.idle_cnt < char_time) begin
        st_next.idle_cnt = st_reg.idle_cnt + 4'h1;
      end
    end
    if (bit_tick && rx_line && st_reg.idle_armed && st_reg.idle_cnt == char_time - 4'h1
        && !(st_reg.ctrl[SPSF_C_ILT] && st_reg.in_frame)) begin
      set_v[SPSF_IDLE] = 1'b1;
      st_next.idle_armed = 1'b0;
    end
    // Set wins over clear
    st_next.flags = (st_reg.flags & ~clr_v) | set_v;
    if (rd_stat) begin
      st_next.armed = st_reg.flags;
    end else begin
      st_next.armed = st_reg.armed & ~clr_v;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      st_reg <= '0;
      st_reg.flags <= SPSF_STATUS_RST;
      st_reg.ctrl <= SPSF_CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs, all straight from state
  always_comb begin
    prdata = st_reg.prdata;
    pready = st_reg.pready;
    pslverr = st_reg.pslverr;
    tx_buf_data = st_reg.tx_buf;
    tx_buf_empty = st_reg.flags[SPSF_TX_BUFFER_EMPTY_FLAG];
    tx_preamble_req = st_reg.pre_req;
    tx_break_req = st_reg.ctrl[SPSF_C_SBK];
    tx_enable = st_reg.ctrl[SPSF_C_TE];
    cfg_nine_bit = st_reg.ctrl[SPSF_C_NINE];
    cfg_parity_en = st_reg.ctrl[SPSF_C_PE];
    cfg_parity_odd = st_reg.ctrl[SPSF_C_PODD];
  end

  // ==========================================================
  // Checks
  sequence s_stat_rd;
    rd_stat;
  endsequence

  sequence s_data_rd;
    rd_data;
  endsequence

  chk_tx_buffer_empty_flag_on_load: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    tx_load |=> st_reg.flags[SPSF_TX_BUFFER_EMPTY_FLAG])
    else $error("buffer-empty not set after shifter load");

  chk_tx_buffer_empty_flag_clr_seq: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    $fell(st_reg.flags[SPSF_TX_BUFFER_EMPTY_FLAG]) |-> $past(wr_data && st_reg.armed[SPSF_TX_BUFFER_EMPTY_FLAG]))
    else $error("buffer-empty cleared without status read and data write");

  chk_tc_set_idle: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    (st_reg.flags[SPSF_TX_BUFFER_EMPTY_FLAG] && !tx_busy && !st_reg.pre_req && !st_reg.ctrl[SPSF_C_SBK] && !tc_clr)
    |=> st_reg.flags[SPSF_TC])
    else $error("done flag not set while idle");

  chk_tc_clr_seq: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    $fell(st_reg.flags[SPSF_TC]) |-> $past(tc_clr && st_reg.armed[SPSF_TC]))
    else $error("done flag cleared without valid sequence");

  // ==========================================================
  // Clear sequences
  // Status read and data read are never in adjacent cycles on this bus,
  // so the checks key on the latched mask rather than on a two-step chain.
  // A character landing in the clearing cycle is left out: set wins there.
  chk_stat_latch: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    s_stat_rd |=> st_reg.armed == $past(st_reg.flags))
    else $error("status read did not latch the flags seen");

  chk_rx_full_flag_clear: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    s_data_rd ##0 (st_reg.armed[SPSF_RX_FULL_FLAG] && !rx_stop_strobe) |=> !st_reg.flags[SPSF_RX_FULL_FLAG])
    else $error("receive-full not cleared by read sequence");

  chk_ovr_clear: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    s_data_rd ##0 (st_reg.armed[SPSF_OVR] && !rx_stop_strobe) |=> !st_reg.flags[SPSF_OVR])
    else $error("overrun not cleared by read sequence");

  chk_nf_clear: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    s_data_rd ##0 (st_reg.armed[SPSF_NF] && !rx_stop_strobe) |=> !st_reg.flags[SPSF_NF])
    else $error("noise flag not cleared by read sequence");

  chk_fe_clear: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    s_data_rd ##0 (st_reg.armed[SPSF_FE] && !rx_stop_strobe) |=> !st_reg.flags[SPSF_FE])
    else $error("framing flag not cleared by read sequence");

  chk_pf_clear: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    s_data_rd ##0 (st_reg.armed[SPSF_PF] && !rx_stop_strobe) |=> !st_reg.flags[SPSF_PF])
    else $error("parity flag not cleared by read sequence");

  // Idle can only set on a bit tick, so a tick-free read must clear it
  chk_idle_clear: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    s_data_rd ##0 (st_reg.armed[SPSF_IDLE] && !bit_tick) |=> !st_reg.flags[SPSF_IDLE])
    else $error("idle flag not cleared by read sequence");

  // Status writes must not disturb flags beyond hardware set events
  chk_status_ro: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    (acc && pwrite && (paddr == SPSF_OFF_STATUS) && !rx_stop_strobe)
    |=> st_reg.flags == ($past(st_reg.flags) | $past(set_v)))
    else $error("status write changed a flag");

  // ==========================================================
  // Receive and transmit events
  chk_noise_set: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    (rx_ok && spsf_noisy3(rx_stop_samples)) |=> st_reg.flags[SPSF_NF])
    else $error("noise flag not set for noisy stop bit");

  chk_idle_rearm: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    rx_ok |=> st_reg.idle_armed)
    else $error("idle detection not rearmed by new character");

  chk_preamble_drop: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    (tx_load && !te_rise) |=> !st_reg.pre_req)
    else $error("preamble request survived shifter load");

  // Bus answer is a single-cycle pulse
  chk_pready_pulse: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    st_reg.pready |=> !st_reg.pready)
    else $error("pready held longer than one cycle");

  chk_rx_accept: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    (rx_stop_strobe && !st_reg.flags[SPSF_RX_FULL_FLAG])
    |=> st_reg.flags[SPSF_RX_FULL_FLAG] && st_reg.flags[SPSF_FE] == !$past(stop_bit))
    else $error("character accept flags wrong");

  chk_ovr_discard: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    (rx_stop_strobe && st_reg.flags[SPSF_RX_FULL_FLAG] && !rx_clr)
    |=> st_reg.flags[SPSF_OVR] && $stable(st_reg.rx_data) && $stable(st_reg.flags[SPSF_FE]))
    else $error("overrun did not discard character");

  chk_idle_once: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    $rose(st_reg.flags[SPSF_IDLE]) |-> !st_reg.idle_armed && st_reg.idle_cnt == char_time)
    else $error("idle set without full character time or twice");

  chk_parity_err: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    (rx_ok && !st_reg.ctrl[SPSF_C_PE]) |=> !st_reg.flags[SPSF_PF])
    else $error("parity error set with parity disabled");

  chk_break_req: assert property (@(posedge mclk) disable iff (!rst_sync_reg)
    st_reg.ctrl[SPSF_C_SBK] |-> tx_break_req ##1 (tx_break_req || !st_reg.ctrl[SPSF_C_SBK]))
    else $error("break request dropped while send-break set");
endmodule : spsf_status

// File: sim/spsf_far_end.sv
`timescale 1ns/1ns
// ========================================
// Far-end transceiver, bits arrive pre-sampled
module spsf_far_end (
  input wire logic mclk,
  output logic tx_load,
  output logic tx_busy,
  output logic rx_line,
  output logic bit_tick,
  output logic rx_start_strobe,
  output logic [6:0] rx_start_samples,
  output logic rx_bit_strobe,
  output logic [2:0] rx_bit_samples,
  output logic rx_stop_strobe,
  output logic [2:0] rx_stop_samples
);
  // Line idles high; sample buses carry junk outside strobes
  initial begin
    {tx_load, tx_busy, bit_tick, rx_start_strobe, rx_bit_strobe, rx_stop_strobe} = 6'h00;
    {rx_line, rx_start_samples, rx_bit_samples, rx_stop_samples} = 14'h2AAA;
  end
  // Shifter load pulse, busy as a level
  task automatic tx_step(input logic ld, input logic busy);
    @(posedge mclk);
    tx_load <= ld;
    tx_busy <= busy;
    @(posedge mclk);
    tx_load <= 1'b0;
  endtask : tx_step
  // One bit per cycle; noisy flips one start sample
  task automatic send_char(input logic [8:0] d, input int n, input logic stp, input logic noisy);
    @(posedge mclk);
    rx_line <= 1'b0;
    bit_tick <= 1'b1;
    rx_start_strobe <= 1'b1;
    rx_start_samples <= noisy ? 7'h08 : 7'h00;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rx_start_strobe <= 1'b0;
      rx_line <= d[i];
      rx_bit_strobe <= 1'b1;
      rx_bit_samples <= {3{d[i]}};
    end
    @(posedge mclk);
    rx_bit_strobe <= 1'b0;
    rx_line <= stp;
    rx_stop_strobe <= 1'b1;
    rx_stop_samples <= {3{stp}};
    @(posedge mclk);
    {rx_stop_strobe, bit_tick, rx_line} <= 3'h1;
    rx_start_samples <= 7'h55;
    rx_bit_samples <= ~rx_bit_samples;
    rx_stop_samples <= ~rx_stop_samples;
  endtask : send_char
  // Bit times on an idle line
  task automatic idle_ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      bit_tick <= 1'b1;
      @(posedge mclk);
      bit_tick <= 1'b0;
    end
  endtask : idle_ticks
endmodule : spsf_far_end

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import spsf_pkg::*;
  localparam logic [7:0] a_st = SPSF_OFF_STATUS;
  localparam logic [7:0] a_dt = SPSF_OFF_DATA;
  localparam logic [7:0] a_ct = SPSF_OFF_CTRL;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tx_load, tx_busy, tx_buf_empty, tx_preamble_req, tx_break_req, tx_enable;
  logic cfg_nine_bit, cfg_parity_en, cfg_parity_odd, rx_line, bit_tick, rx_start_strobe;
  logic rx_bit_strobe, rx_stop_strobe, er;
  logic [8:0] tx_buf_data;
  logic [6:0] rx_start_samples;
  logic [2:0] rx_bit_samples, rx_stop_samples;
  int num_errors = 0;
  int checks = 0;
  // ========================================
  // Clock, 50 ns period
  initial begin
    forever #25 mclk = ~mclk;
  end
  spsf_status i_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_load, .tx_busy, .tx_buf_data, .tx_buf_empty, .tx_preamble_req, .tx_break_req,
    .tx_enable, .cfg_nine_bit, .cfg_parity_en, .cfg_parity_odd, .rx_line, .bit_tick,
    .rx_start_strobe, .rx_start_samples, .rx_bit_strobe, .rx_bit_samples, .rx_stop_strobe,
    .rx_stop_samples);
  spsf_far_end i_far (.mclk, .tx_load, .tx_busy, .rx_line, .bit_tick, .rx_start_strobe,
    .rx_start_samples, .rx_bit_strobe, .rx_bit_samples, .rx_stop_strobe, .rx_stop_samples);
  // ========================================
  // Shared checking and bus tasks
  task automatic give_verdict;
    $display("TB: checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Request held until pready is seen high; bounded wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge mclk);
    penable <= 1'b1;
    // Look at pready between edges, so the next rising edge is the taking one
    do begin
      @(negedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    @(posedge mclk);
    {psel, penable} <= 2'b00;
    // Let the taking edge settle before callers look at outputs
    @(negedge mclk);
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask : rd_chk
  // ========================================
  // Scenarios
  task automatic t_reset;
    apb(1'b1, a_dt, 32'h1A5);
    cmp({23'h0, tx_buf_data}, 32'h1A5);
    rd_chk(a_st, 32'hC0);
    apb(1'b1, a_st, 32'hFF);
    rd_chk(a_st, 32'hC0);
    apb(1'b0, 8'h0C, 32'h0);
    cmp({31'h0, er}, 32'h1);
    $display("TB: reset test done");
  endtask : t_reset
  task automatic t_tx;
    apb(1'b1, a_dt, 32'h55);
    rd_chk(a_st, 32'h00);
    i_far.tx_step(1'b1, 1'b1);
    rd_chk(a_st, 32'h80);
    i_far.tx_step(1'b0, 1'b0);
    rd_chk(a_st, 32'hC0);
    apb(1'b1, a_ct, 32'h01);
    cmp({31'h0, tx_break_req}, 32'h1);
    rd_chk(a_st, 32'h80);
    apb(1'b1, a_ct, 32'h00);
    rd_chk(a_st, 32'hC0);
    apb(1'b1, a_ct, 32'h20);
    cmp({31'h0, tx_preamble_req}, 32'h1);
    rd_chk(a_st, 32'h80);
    i_far.tx_step(1'b1, 1'b0);
    rd_chk(a_st, 32'hC0);
    $display("TB: transmit test done");
  endtask : t_tx
  task automatic t_rx;
    i_far.send_char(9'h05A, 8, 1'b1, 1'b0);
    rd_chk(a_dt, 32'h5A);
    rd_chk(a_st, 32'hE0);
    rd_chk(a_dt, 32'h5A);
    rd_chk(a_st, 32'hC0);
    i_far.send_char(9'h03C, 8, 1'b1, 1'b0);
    i_far.send_char(9'h0C3, 8, 1'b0, 1'b1);
    rd_chk(a_st, 32'hE8);
    rd_chk(a_dt, 32'h3C);
    rd_chk(a_st, 32'hC0);
    $display("TB: receive test done");
  endtask : t_rx
  task automatic t_err;
    apb(1'b1, a_ct, 32'h08);
    cmp({31'h0, cfg_parity_en}, 32'h1);
    i_far.send_char(9'h001, 8, 1'b0, 1'b1);
    rd_chk(a_st, 32'hE7);
    apb(1'b0, a_dt, 32'h0);
    rd_chk(a_st, 32'hC0);
    apb(1'b1, a_ct, 32'h18);
    i_far.send_char(9'h001, 8, 1'b1, 1'b0);
    rd_chk(a_st, 32'hE0);
    apb(1'b0, a_dt, 32'h0);
    rd_chk(a_st, 32'hC0);
    $display("TB: error flag test done");
  endtask : t_err
  // Idle threshold: stop and trailing ones count only when not select
  task automatic t_idle(input logic idle_count_select, input logic nine);
    int need;
    need = idle_count_select ? (nine ? 11 : 10) : 1;
    apb(1'b1, a_ct, {29'h0, nine, idle_count_select, 1'b0});
    i_far.send_char(9'h1FF, nine ? 9 : 8, 1'b1, 1'b0);
    i_far.idle_ticks(need - 1);
    rd_chk(a_st, 32'hE0);
    i_far.idle_ticks(1);
    rd_chk(a_st, 32'hF0);
    apb(1'b0, a_dt, 32'h0);
    i_far.idle_ticks(12);
    rd_chk(a_st, 32'hC0);
    $display("TB: idle test done");
  endtask : t_idle
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_tx();
    t_rx();
    t_err();
    for (int k = 0; k < 4; k++) begin
      t_idle(k[0], k[1]);
    end
    give_verdict();
  end
endmodule : tb_top
